// file: qpd_device.sv
// Quad pot serial command decoder: six 9-bit locations behind the serial link.
// Assumes the host makes sck and frames commands with chip select; mclk mirrors settings and registers the reset request.
`timescale 1ns/1ps

// Overview of operation
// [RULE1] Command byte: address, opcode, two data bits
// [RULE2] Opcodes: read, write, increment, decrement
// [RULE3] Step commands only valid on wipers
// [RULE4] Output high six bits, then error flag
// [RULE5] Six mapped addresses, rest reserved
// [RULE6] Read returns nine bits, else output high
// [RULE7] Data word: command bit plus data byte
// [RULE8] Top data bit ignored, flag shares slot
// [RULE9] Flag high valid, low unsupported
// [RULE10] Command after nonvolatile write flags error
// [RULE11] Partial commands not multiple of eight ignored
// [RULE12] After error ignore commands, output low
// [RULE13] Execute on full count; deselect discards
// [RULE14] Ignore link until next select edge
// [RULE15] High-voltage select behaves like normal select
// [RULE16] Step commands eight clocks, others sixteen
// [RULE17] Host idles deselected, keeps strings short
// [RULE18] Sample on rising, drive on falling edge
// [RULE19] Select starts driving, clears bit counter
// [RULE20] Write lands only after sixteen clocks
// [RULE21] Increment saturates at full scale
// [RULE22] Commands run back to back in frame
module qpd_device #(
   parameter logic [qpd_pkg::DATA_W-1:0] FULL_SCALE = qpd_pkg::WIPER_FULL_SCALE,
   parameter logic [15:0] NV_ADDR_MASK = qpd_pkg::NV_ADDR_NONE
) (
   // Serial link
   qpd_spi_if.dev link,
   // Local clock domain
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   // Settings mirrored into mclk
   output logic [qpd_pkg::NUM_LOC-1:0][qpd_pkg::DATA_W-1:0] setting_q,
   output logic setting_upd_q
);
   import qpd_pkg::*;

   // mclk domain
   logic rst_q;
   logic tg_meta_q;
   logic tg_sync_q;
   logic tg_last_q;
   // sck domain
   logic srst_meta_q;
   logic srst_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic [7:0] cmd_q;
   logic err_q;
   logic nv_pend_q;
   logic sdo_q;
   logic upd_tgl_q;
   logic [DATA_W-1:0] mem_q [NUM_LOC];

   // Select decode
   logic sel;
   logic serial_rst;
   // RULE15 either select level
   assign sel = ~link.cs_n | link.cs_hv;
   // RULE14 held in reset while deselected
   assign serial_rst = ~sel;

   // Early decode at the sixth rising edge, taken from the live input bit
   logic [ADDR_W-1:0] flag_addr;
   logic [OP_W-1:0] flag_op;
   logic flag_rw;
   logic [NUM_LOC-1:0] flag_hit;
   logic flag_valid;
   logic flag_bad;
   // RULE1 field layout
   assign flag_addr = sh_q[4:1];
   assign flag_op = {sh_q[0], link.sdi};
   // RULE2 read and write reach every location
   assign flag_rw = (flag_op == QPD_OP_READ) || (flag_op == QPD_OP_WRITE);
   // RULE3 step opcodes only on wipers
   assign flag_valid = |(flag_hit & (flag_rw ? {NUM_LOC{1'b1}} : LOC_IS_WIPER));
   // RULE10 nonvolatile write pending
   assign flag_bad = ~flag_valid | nv_pend_q;

   // Command byte complete at the eighth rising edge
   logic [7:0] cur_byte;
   logic [OP_W-1:0] cur_op;
   logic cur_step;
   logic byte_end;
   logic word_end;
   logic cmd_end;
   assign cur_byte = {sh_q[6:0], link.sdi};
   assign cur_op = cur_byte[CMD_OP_LSB +: OP_W];
   assign cur_step = (cur_op == QPD_OP_INC) || (cur_op == QPD_OP_DEC);
   assign byte_end = (bit_q == CNT_BYTE_END);
   assign word_end = (bit_q == CNT_WORD_END);
   // RULE16 eight clocks for steps, sixteen otherwise
   assign cmd_end = (byte_end && cur_step) || word_end;

   // Execution strobes
   logic do_step;
   logic do_wr;
   logic [ADDR_W-1:0] ex_addr;
   logic [DATA_W-1:0] wr_data;
   logic [NUM_LOC-1:0] ex_hit;
   // RULE13 act only on the last clock of a command
   assign do_step = byte_end && cur_step && !err_q;
   // RULE20 write lands on the sixteenth clock only
   assign do_wr = word_end && (cmd_q[CMD_OP_LSB +: OP_W] == QPD_OP_WRITE) && !err_q;
   assign ex_addr = word_end ? cmd_q[CMD_ADDR_LSB +: ADDR_W] : cur_byte[CMD_ADDR_LSB +: ADDR_W];
   // RULE7 command bit on top of the data byte
   // RULE8 spare bit never stored
   assign wr_data = {cmd_q[CMD_D8_POS], cur_byte};

   // Read path, addressed from the live byte on the eighth bit, then from the latch
   logic [ADDR_W-1:0] rd_addr;
   logic [OP_W-1:0] rd_op;
   logic [NUM_LOC-1:0] rd_hit;
   logic [DATA_W-1:0] rd_word;
   logic [3:0] rd_idx;
   logic rd_slot;
   logic out_bit;
   assign rd_addr = byte_end ? sh_q[6:3] : cmd_q[CMD_ADDR_LSB +: ADDR_W];
   assign rd_op = byte_end ? sh_q[2:1] : cmd_q[CMD_OP_LSB +: OP_W];
   assign rd_idx = CNT_TOP - bit_q;
   assign rd_slot = (bit_q >= CNT_BYTE_END) && (rd_op == QPD_OP_READ);
   // RULE4 high for six bits, flag on seventh
   // RULE6 nine data bits for reads, high otherwise
   // RULE9 flag low only once the error is latched
   // RULE12 output pinned low after an error
   assign out_bit = err_q ? 1'b0 : (rd_slot ? rd_word[rd_idx] : 1'b1);

   // Per-location decode and storage
   logic [NUM_LOC-1:0][DATA_W-1:0] rd_terms;
   genvar gi;
   generate
      for (gi = 0; gi < NUM_LOC; gi++) begin : g_loc
         logic [DATA_W-1:0] cur;
         logic [DATA_W-1:0] nxt;
         assign cur = mem_q[gi];
         // RULE5 fixed address per location
         assign flag_hit[gi] = (flag_addr == LOC_ADDR[gi]);
         assign ex_hit[gi] = (ex_addr == LOC_ADDR[gi]);
         assign rd_hit[gi] = (rd_addr == LOC_ADDR[gi]);
         assign rd_terms[gi] = rd_hit[gi] ? cur : '0;
         // RULE21 increment stops at full scale; decrement stops at zero
         assign nxt = (cur_op == QPD_OP_INC) ? ((cur < FULL_SCALE) ? cur + 9'h001 : cur)
                                             : ((cur != WIPER_ZERO) ? cur - 9'h001 : cur);

         // Storage survives deselect; only the system reset reloads it
         always_ff @(posedge link.sck or posedge srst_q) begin
            if (srst_q) begin
               mem_q[gi] <= LOC_IS_WIPER[gi] ? WIPER_RESET : TERM_RESET;
            end else if (do_wr && ex_hit[gi]) begin
               mem_q[gi] <= wr_data;
            end else if (do_step && ex_hit[gi] && LOC_IS_WIPER[gi]) begin
               mem_q[gi] <= nxt;
            end
         end
      end
   endgenerate

   // Read word is the OR of the one hit location
   always_comb begin
      rd_word = '0;
      for (int i = 0; i < NUM_LOC; i++) begin
         rd_word = rd_word | rd_terms[i];
      end
   end

   // Reset request held in mclk; asserts storage reset at once
   always_ff @(posedge mclk) begin
      rst_q <= ~rstn;
   end

   // Release of storage reset follows sck; the first two rising edges after reset do it
   always_ff @(posedge link.sck or posedge rst_q) begin
      if (rst_q) begin
         srst_meta_q <= 1'b1;
         srst_q <= 1'b1;
      end else begin
         srst_meta_q <= 1'b0;
         srst_q <= srst_meta_q;
      end
   end

   // Update toggle for the mclk mirror; one flip per executed change
   always_ff @(posedge link.sck or posedge srst_q) begin
      if (srst_q) begin
         upd_tgl_q <= 1'b0;
      end else if (do_wr || do_step) begin
         upd_tgl_q <= ~upd_tgl_q;
      end
   end

   // RULE18 input shift on rising edge
   // RULE19 counter cleared by select
   // RULE11 partial count discarded at deselect
   always_ff @(posedge link.sck or posedge serial_rst) begin
      if (serial_rst) begin
         sh_q <= 8'h00;
         bit_q <= 4'h0;
      end else begin
         sh_q <= cur_byte;
         // RULE22 next command starts on the following bit
         bit_q <= cmd_end ? 4'h0 : bit_q + 4'h1;
      end
   end

   // Command latch and error state, both cleared only by deselect
   always_ff @(posedge link.sck or posedge serial_rst) begin
      if (serial_rst) begin
         cmd_q <= 8'h00;
         err_q <= 1'b0;
         nv_pend_q <= 1'b0;
      end else begin
         if (byte_end) begin
            cmd_q <= cur_byte;
         end
         // RULE12 sticky until deselect
         if (bit_q == CNT_FLAG && flag_bad) begin
            err_q <= 1'b1;
         end
         // RULE10 nonvolatile write arms the error
         if (do_wr && NV_ADDR_MASK[ex_addr]) begin
            nv_pend_q <= 1'b1;
         end
      end
   end

   // RULE18 output changes on falling edge
   // RULE19 high from select until the first fall
   always_ff @(negedge link.sck or posedge serial_rst) begin
      if (serial_rst) begin
         sdo_q <= 1'b1;
      end else begin
         sdo_q <= out_bit;
      end
   end

   // RULE19 pin driven while selected
   assign link.sdo = sdo_q;
   assign link.sdo_oe = sel;

   // Toggle crosses on two flops; storage is stable for eight sck periods after it
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         tg_meta_q <= 1'b0;
         tg_sync_q <= 1'b0;
         tg_last_q <= 1'b0;
      end else if (ce) begin
         tg_meta_q <= upd_tgl_q;
         tg_sync_q <= tg_meta_q;
         tg_last_q <= tg_sync_q;
      end
   end

   // Mirror copy, taken whole when the toggle edge arrives
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         setting_upd_q <= 1'b0;
         for (int i = 0; i < NUM_LOC; i++) begin
            setting_q[i] <= LOC_IS_WIPER[i] ? WIPER_RESET : TERM_RESET;
         end
      end else if (ce) begin
         setting_upd_q <= tg_sync_q ^ tg_last_q;
         if (tg_sync_q ^ tg_last_q) begin
            for (int i = 0; i < NUM_LOC; i++) begin
               setting_q[i] <= mem_q[i];
            end
         end
      end
   end

endmodule

// file: qpd_pkg.sv
// Shared constants for the quad pot serial command decoder and its host end.
// Assumes both ends and the bench import it; no clocks or logic live here.
package qpd_pkg;

   // Field widths
   localparam int ADDR_W = 4;
   localparam int OP_W = 2;
   localparam int DATA_W = 9;
   localparam int NUM_LOC = 6;
   localparam int FRAME_W = 16;

   // Command byte field positions (bit 7 is shifted in first)
   localparam int CMD_ADDR_LSB = 4;
   localparam int CMD_OP_LSB = 2;
   localparam int CMD_SPARE_POS = 1;
   localparam int CMD_D8_POS = 0;

   // Bit counter values (rising edges already taken in the command)
   localparam logic [3:0] CNT_FLAG = 4'h5;
   localparam logic [3:0] CNT_BYTE_END = 4'h7;
   localparam logic [3:0] CNT_WORD_END = 4'hF;
   localparam logic [3:0] CNT_TOP = 4'hF;

   // Opcodes
   typedef enum logic [1:0] {
      QPD_OP_WRITE = 2'h0,
      QPD_OP_INC = 2'h1,
      QPD_OP_DEC = 2'h2,
      QPD_OP_READ = 2'h3
   } qpd_op_t;

   // Location map: index 0..5 to address, and which indices are wipers
   localparam logic [ADDR_W-1:0] ADDR_WIPER_0 = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_WIPER_1 = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_TERM_0 = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_WIPER_2 = 4'h6;
   localparam logic [ADDR_W-1:0] ADDR_WIPER_3 = 4'h7;
   localparam logic [ADDR_W-1:0] ADDR_TERM_1 = 4'hA;
   localparam logic [NUM_LOC-1:0][ADDR_W-1:0] LOC_ADDR = {ADDR_TERM_1, ADDR_WIPER_3,
      ADDR_WIPER_2, ADDR_TERM_0, ADDR_WIPER_1, ADDR_WIPER_0};
   localparam logic [NUM_LOC-1:0] LOC_IS_WIPER = 6'h1B;

   // Reset values and wiper limits
   localparam logic [DATA_W-1:0] WIPER_RESET = 9'h080;
   localparam logic [DATA_W-1:0] TERM_RESET = 9'h1FF;
   localparam logic [DATA_W-1:0] WIPER_FULL_SCALE = 9'h100;
   localparam logic [DATA_W-1:0] WIPER_ZERO = 9'h000;
   localparam logic [15:0] NV_ADDR_NONE = 16'h0000;

   // Link timing for the host divider
   localparam int MCLK_PERIOD_NS = 10;
   localparam int SCK_PERIOD_NS = 160;
   localparam int SCK_HALF_CYC = SCK_PERIOD_NS / (2 * MCLK_PERIOD_NS);
   localparam int DIV_W = 8;

endpackage

// file: qpd_spi_if.sv
// Serial link between the pot command decoder and its host.
// Assumes the host makes the serial clock; the data-out pin is pulled high when undriven.
`timescale 1ns/1ps
interface qpd_spi_if;

   // Host driven pins
   logic sck;
   logic cs_n;
   logic cs_hv;
   logic sdi;

   // Device driven pin with its enable
   logic sdo;
   logic sdo_oe;

   // Resolved level seen by the host, pull-up when released
   logic sdo_line;
   assign sdo_line = sdo_oe ? sdo : 1'b1;

   modport dev (
      input sck,
      input cs_n,
      input cs_hv,
      input sdi,
      output sdo,
      output sdo_oe
   );

   modport host (
      output sck,
      output cs_n,
      output cs_hv,
      output sdi,
      input sdo_line
   );

endinterface

// file: qpd_host.sv
// Host end: issues one command per select frame and returns the answer.
// Assumes mclk at the package rate; sck is divided down here and driven out in mode 0,0.
`timescale 1ns/1ps
module qpd_host #(
   parameter int SCK_HALF = qpd_pkg::SCK_HALF_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   // Serial link
   qpd_spi_if.host link,
   // Command request
   input wire logic req_valid,
   input wire logic [qpd_pkg::OP_W-1:0] req_op,
   input wire logic [qpd_pkg::ADDR_W-1:0] req_addr,
   input wire logic [qpd_pkg::DATA_W-1:0] req_data,
   input wire logic req_hv,
   output logic req_ready_q,
   // Answer
   output logic done_q,
   output logic [qpd_pkg::DATA_W-1:0] rdata_q,
   output logic cmd_err_q
);
   import qpd_pkg::*;

   typedef enum logic [3:0] {
      QPD_H_IDLE = 4'h1,
      QPD_H_LOW = 4'h2,
      QPD_H_HIGH = 4'h4,
      QPD_H_GAP = 4'h8
   } qpd_hstate_t;

   qpd_hstate_t st_q;
   logic [DIV_W-1:0] div_q;
   logic [3:0] cnt_q;
   logic long_q;
   logic [FRAME_W-1:0] tx_q;
   logic [FRAME_W-1:0] rx_q;
   logic sck_q;
   logic cs_n_q;
   logic cs_hv_q;
   logic sdi_q;
   logic sdo_meta_q;
   logic sdo_sync_q;

   // Phase and frame length decode
   logic half_done;
   logic last_bit;
   logic req_step;
   assign half_done = (div_q == DIV_W'(SCK_HALF - 1));
   assign last_bit = (cnt_q == (long_q ? CNT_WORD_END : CNT_BYTE_END));
   // RULE16 eight clocks for steps
   assign req_step = (req_op == QPD_OP_INC) || (req_op == QPD_OP_DEC);

   assign link.sck = sck_q;
   assign link.cs_n = cs_n_q;
   assign link.cs_hv = cs_hv_q;
   assign link.sdi = sdi_q;

   // Pin input crosses two flops before use
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         sdo_meta_q <= 1'b1;
         sdo_sync_q <= 1'b1;
      end else if (ce) begin
         sdo_meta_q <= link.sdo_line;
         sdo_sync_q <= sdo_meta_q;
      end
   end

   // Half-period divider, restarted on every phase change; frozen with ce like all else
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         div_q <= '0;
      end else if (ce) begin
         div_q <= (half_done || st_q == QPD_H_IDLE) ? '0 : div_q + DIV_W'(1);
      end
   end

   // Frame sequencer
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         st_q <= QPD_H_IDLE;
         sck_q <= 1'b0;
         cs_n_q <= 1'b1;
         cs_hv_q <= 1'b0;
         sdi_q <= 1'b0;
         cnt_q <= 4'h0;
         long_q <= 1'b0;
         tx_q <= '0;
         rx_q <= '0;
         req_ready_q <= 1'b0;
         done_q <= 1'b0;
         rdata_q <= '0;
         cmd_err_q <= 1'b0;
      end else if (ce) begin
         done_q <= 1'b0;
         unique case (st_q)
            QPD_H_IDLE: begin
               req_ready_q <= 1'b1;
               if (req_valid && req_ready_q) begin
                  // RULE1 address, opcode, spare zero, top data bit
                  tx_q <= {req_addr, req_op, 1'b0, req_data};
                  sdi_q <= req_addr[ADDR_W-1];
                  long_q <= ~req_step;
                  cnt_q <= 4'h0;
                  // RULE15 optional high-voltage select
                  cs_n_q <= req_hv;
                  cs_hv_q <= req_hv;
                  req_ready_q <= 1'b0;
                  st_q <= QPD_H_LOW;
               end
            end
            QPD_H_LOW: begin
               if (half_done) begin
                  // RULE18 sample as sck rises
                  sck_q <= 1'b1;
                  rx_q <= {rx_q[FRAME_W-2:0], sdo_sync_q};
                  st_q <= QPD_H_HIGH;
               end
            end
            QPD_H_HIGH: begin
               if (half_done) begin
                  sck_q <= 1'b0;
                  if (last_bit) begin
                     // RULE17 deselect after every command
                     cs_n_q <= 1'b1;
                     cs_hv_q <= 1'b0;
                     st_q <= QPD_H_GAP;
                  end else begin
                     cnt_q <= cnt_q + 4'h1;
                     tx_q <= {tx_q[FRAME_W-2:0], 1'b0};
                     sdi_q <= tx_q[FRAME_W-2];
                     st_q <= QPD_H_LOW;
                  end
               end
            end
            QPD_H_GAP: begin
               if (half_done) begin
                  done_q <= 1'b1;
                  rdata_q <= rx_q[DATA_W-1:0];
                  // Seventh bit received carries the flag, high when valid
                  cmd_err_q <= long_q ? ~rx_q[9] : ~rx_q[1];
                  st_q <= QPD_H_IDLE;
               end
            end
            default: begin
               st_q <= QPD_H_IDLE;
            end
         endcase
      end
   end

endmodule

// file: qpd_assertions.sv
// Concurrent checks on the serial link between the pot decoder and its host.
// Assumes mode 0,0 from the host and link signals passed in as plain inputs.
`timescale 1ns/1ps
module qpd_assertions (
   // Local clock domain
   input wire logic mclk,
   input wire logic rstn,
   // Serial link
   input wire logic sck,
   input wire logic cs_n,
   input wire logic cs_hv,
   input wire logic sdi,
   input wire logic sdo,
   input wire logic sdo_oe,
   input wire logic sdo_line
);
   import qpd_pkg::*;

   logic desel;
   logic [4:0] cnt_q;
   logic [5:0] shift_q;
   logic [5:0] cmd_q;
   logic wiper_hit;
   logic term_hit;
   logic step_op;
   logic vld;

   // Expected validity of the captured address and opcode
   assign desel = cs_n & ~cs_hv;
   assign wiper_hit = (cmd_q[5:2] == ADDR_WIPER_0) | (cmd_q[5:2] == ADDR_WIPER_1) |
      (cmd_q[5:2] == ADDR_WIPER_2) | (cmd_q[5:2] == ADDR_WIPER_3);
   assign term_hit = (cmd_q[5:2] == ADDR_TERM_0) | (cmd_q[5:2] == ADDR_TERM_1);
   assign step_op = (cmd_q[1:0] == QPD_OP_INC) | (cmd_q[1:0] == QPD_OP_DEC);
   assign vld = wiper_hit | (term_hit & ~step_op);

   // Rise counter and command capture, cleared whenever deselected
   always_ff @(posedge sck or posedge desel) begin
      if (desel) begin
         cnt_q <= 5'h00;
         shift_q <= 6'h00;
         cmd_q <= 6'h00;
      end else begin
         cnt_q <= (cnt_q == 5'h1F) ? cnt_q : cnt_q + 5'h01;
         shift_q <= {shift_q[4:0], sdi};
         if (cnt_q == 5'h05) begin
            cmd_q <= {shift_q[4:0], sdi};
         end
      end
   end

   AST_HEAD_HIGH: assert property (@(posedge sck) disable iff (desel)
      cnt_q < 5'h06 |-> sdo) else $error("output low during command head");
   AST_FLAG: assert property (@(posedge sck) disable iff (desel)
      cnt_q == 5'h06 |-> sdo == vld) else $error("error flag disagrees with command");
   AST_ERR_STICKY: assert property (@(posedge sck) disable iff (desel)
      cnt_q > 5'h06 && !vld |-> !sdo) else $error("output high after command error");
   AST_TAIL_HIGH: assert property (@(posedge sck) disable iff (desel)
      cnt_q > 5'h06 && vld && cmd_q[1:0] != QPD_OP_READ |-> sdo)
      else $error("output low after flag of a non-read");
   AST_OE_SELECT: assert property (@(posedge mclk) disable iff (!rstn)
      sdo_oe == !desel) else $error("output enable does not follow select");
   AST_HV_SELECT: assert property (@(posedge mclk) disable iff (!rstn)
      cs_hv |-> sdo_oe && sdo_line == sdo) else $error("high-voltage select not driving");
   AST_FIRST_BIT: assert property (@(posedge mclk) disable iff (!rstn)
      $fell(desel) |-> sdo ##1 sdo) else $error("first output bit not high");
   AST_FALL_ONLY: assert property (@(posedge mclk) disable iff (!rstn || desel)
      sck && $past(sck) && !$past(desel) |-> $stable(sdo))
      else $error("output moved with clock high");
endmodule

// file: qpd_tb_top.sv
// Self-checking bench: host and decoder joined by the link, driven from the host side.
// Assumes a 100 MHz mclk; the host divides it down to the 160 ns serial clock.
`timescale 1ns/1ps
module qpd_tb_top;
   import qpd_pkg::*;

   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic req_valid = 1'b0;
   logic [1:0] req_op = 2'h0;
   logic [3:0] req_addr = 4'h0;
   logic [8:0] req_data = 9'h000;
   logic req_hv = 1'b0;
   logic req_ready_q;
   logic done_q;
   logic [8:0] rdata_q;
   logic cmd_err_q;
   logic [NUM_LOC-1:0][DATA_W-1:0] setting_q;
   logic setting_upd_q;
   int upd_cnt = 0;
   int err_total = 0;
   int compares = 0;
   int rise_cnt = 0;

   qpd_spi_if qpd_spi_if_i ();
   qpd_device qpd_device_i (.link(qpd_spi_if_i.dev), .mclk(mclk), .rstn(rstn), .ce(1'b1),
      .setting_q(setting_q), .setting_upd_q(setting_upd_q));
   qpd_host qpd_host_i (.mclk(mclk), .rstn(rstn), .ce(1'b1), .link(qpd_spi_if_i.host),
      .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
      .req_hv(req_hv), .req_ready_q(req_ready_q), .done_q(done_q), .rdata_q(rdata_q),
      .cmd_err_q(cmd_err_q));
   qpd_assertions qpd_assertions_i (.mclk(mclk), .rstn(rstn), .sck(qpd_spi_if_i.sck),
      .cs_n(qpd_spi_if_i.cs_n), .cs_hv(qpd_spi_if_i.cs_hv), .sdi(qpd_spi_if_i.sdi),
      .sdo(qpd_spi_if_i.sdo), .sdo_oe(qpd_spi_if_i.sdo_oe), .sdo_line(qpd_spi_if_i.sdo_line));

   // Clock and serial clock rise counter within a frame
   always #5 mclk = ~mclk;
   // Mirror reload pulses within a command; one per executed change
   always @(posedge mclk) begin
      if (setting_upd_q === 1'b1) begin
         upd_cnt++;
      end
   end
   always @(posedge qpd_spi_if_i.sck) begin
      if (!qpd_spi_if_i.cs_n || qpd_spi_if_i.cs_hv) begin
         rise_cnt++;
      end
   end

   task automatic chk_data(input logic [8:0] exp, input logic [8:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask

   task automatic chk_flag(input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask

   task automatic final_report();
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // One command per frame; waits are bounded so a stuck host shows as a mismatch
   task automatic run_cmd(input logic [1:0] op, input logic [3:0] a, input logic [8:0] d,
      input logic hv);
      int n;
      n = 0;
      chk_flag(1'b1, qpd_spi_if_i.sdo_line);
      chk_flag(1'b0, qpd_spi_if_i.sck);
      @(posedge mclk);
      while (req_ready_q !== 1'b1 && n < 100) begin
         @(posedge mclk);
         n++;
      end
      chk_flag(1'b1, req_ready_q);
      rise_cnt = 0;
      upd_cnt = 0;
      req_valid <= 1'b1;
      req_op <= op;
      req_addr <= a;
      req_data <= d;
      req_hv <= hv;
      @(posedge mclk);
      req_valid <= 1'b0;
      n = 0;
      while (done_q !== 1'b1 && n < 3000) begin
         @(posedge mclk);
         n++;
      end
      chk_flag(1'b1, done_q);
      chk_data((op == QPD_OP_INC || op == QPD_OP_DEC) ? 9'h008 : 9'h010, 9'(rise_cnt));
   endtask

   function automatic logic [8:0] exp_wd(input int i);
      return 9'h15A ^ 9'(i * 83);
   endfunction

   task automatic t_reset_values();
      for (int i = 0; i < NUM_LOC; i++) begin
         run_cmd(QPD_OP_READ, LOC_ADDR[i], 9'h000, 1'b0);
         chk_flag(1'b0, cmd_err_q);
         chk_data(LOC_IS_WIPER[i] ? WIPER_RESET : TERM_RESET, rdata_q);
      end
   endtask

   // Write then read back every location, alternating select levels
   task automatic t_write_read();
      for (int i = 0; i < NUM_LOC; i++) begin
         run_cmd(QPD_OP_WRITE, LOC_ADDR[i], exp_wd(i), 1'(i));
         chk_flag(1'b0, cmd_err_q);
         chk_data(9'h1FF, rdata_q);
         chk_data(exp_wd(i), setting_q[i]);
         chk_data(9'h001, 9'(upd_cnt));
         run_cmd(QPD_OP_READ, LOC_ADDR[i], 9'h000, ~1'(i));
         chk_data(exp_wd(i), rdata_q);
         chk_data(9'h000, 9'(upd_cnt));
      end
   endtask

   // Increment saturates at full scale; decrement stops at zero
   task automatic t_step();
      run_cmd(QPD_OP_WRITE, ADDR_WIPER_2, 9'h0FF, 1'b0);
      run_cmd(QPD_OP_INC, ADDR_WIPER_2, 9'h000, 1'b0);
      chk_flag(1'b0, cmd_err_q);
      chk_data(9'h100, setting_q[3]);
      chk_data(9'h001, 9'(upd_cnt));
      run_cmd(QPD_OP_INC, ADDR_WIPER_2, 9'h000, 1'b1);
      run_cmd(QPD_OP_READ, ADDR_WIPER_2, 9'h000, 1'b0);
      chk_data(WIPER_FULL_SCALE, rdata_q);
      run_cmd(QPD_OP_WRITE, ADDR_WIPER_2, 9'h001, 1'b0);
      run_cmd(QPD_OP_DEC, ADDR_WIPER_2, 9'h000, 1'b1);
      chk_data(9'h000, setting_q[3]);
      run_cmd(QPD_OP_DEC, ADDR_WIPER_2, 9'h000, 1'b0);
      run_cmd(QPD_OP_READ, ADDR_WIPER_2, 9'h000, 1'b0);
      chk_data(WIPER_ZERO, rdata_q);
   endtask

   // Step on terminal registers and any command on reserved addresses are refused
   task automatic t_invalid();
      logic hit;
      for (int k = 2; k < NUM_LOC; k += 3) begin
         run_cmd(QPD_OP_INC, LOC_ADDR[k], 9'h000, 1'b0);
         chk_flag(1'b1, cmd_err_q);
         run_cmd(QPD_OP_DEC, LOC_ADDR[k], 9'h000, 1'b1);
         chk_flag(1'b1, cmd_err_q);
         run_cmd(QPD_OP_READ, LOC_ADDR[k], 9'h000, 1'b0);
         chk_data(exp_wd(k), rdata_q);
      end
      for (int a = 0; a < 16; a++) begin
         hit = 1'b0;
         for (int k = 0; k < NUM_LOC; k++) begin
            hit = hit | (LOC_ADDR[k] == 4'(a));
         end
         if (!hit) begin
            run_cmd(2'(a), 4'(a), 9'h0AA, 1'(a >> 2));
            chk_flag(1'b1, cmd_err_q);
            chk_data(9'h000, 9'(upd_cnt));
            if (2'(a) == QPD_OP_READ || 2'(a) == QPD_OP_WRITE) begin
               chk_data(9'h000, rdata_q);
            end
         end
      end
      for (int i = 0; i < NUM_LOC; i++) begin
         if (i != 3) begin
            chk_data(exp_wd(i), setting_q[i]);
         end
      end
   endtask

   // Watchdog, well beyond the roughly 10000 cycles the tests need
   initial begin
      repeat (80000) @(posedge mclk);
      err_total++;
      $display("[FAIL] t=%0t watchdog expired", $time);
      final_report();
   end

   initial begin
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      t_reset_values();
      t_write_read();
      t_step();
      t_invalid();
      final_report();
   end
endmodule
